// ---- adc_mux_defines.vh ----
// Constants for the converter/multiplexer channel control block.
// Assumes a 10 MHz core clock and one-cycle command pulses from the processor I/O bus.
//
// Overview of operation
// R1: Set-channel command loads channel register from working register bits 0 to 5.
// R2: Channel register is six bits wide, addressing up to 64 channels.
// R3: Increment-channel command adds one to the channel register.
// R4: Incrementing from the highest implemented channel wraps to channel zero.
// R5: Processor picks any channel, sets it, then reads the digitized word.
// R6: In sequential use processor increments the channel after each read.
// R7: Random sample: set, convert, clear working register, poll done, read.
// R8: With interrupts enabled, device signals processor whenever a result is ready.
// R9: Clear-channel command resets channel register to zero.
// R10: Convert command clears done flag, digitizes channel, then sets done flag.
// R11: Skip-on-done command requests a skip only while done flag is set.
// R12: Read command drives result left-justified, low bits zero, and clears done.
// R13: Commands act only when the device selection code matches this device.
`ifndef ADC_MUX_DEFINES_VH
`define ADC_MUX_DEFINES_VH

`define CONV_DEV_CODE 6'o53
`define MUX_DEV_CODE 6'o54
`define CHAN_W 6
`define WORD_W 12
`define CHAN_ZERO 6'h00
`define CHAN_ONE 6'h01
`define CHAN_MAX_DEFAULT 6'h3F
`define AC_CHAN_LSB 0
`define RES_ZERO 12'h000
`define CNT_W 10
`define CNT_ZERO 10'h000
`define CNT_ONE 10'h001
`define CONV_CYCLES_FULL 10'h172
`define SETTLE_CYCLES_ADD 10'h014
`define WORD_LEN_MAX 4'hC
`define BIT_STEP_SHIFT 3
`define CLK_MHZ 10
`define CONV_TIME_NS 37000
`define CLK_PERIOD_NS 100
`define SETTLE_TIME_NS 2000

`endif

// ---- adc_mux_conv_timer.v ----
// Conversion timer: counts a conversion time and pulses when done.
// Assumes a start pulse on the core clock; restart reloads the count.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_defines.vh"

module adc_mux_conv_timer (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_start,
	input wire [`CNT_W-1:0] i_cycles,
	output reg o_busy,
	output reg o_done
);

	reg [`CNT_W-1:0] count;

	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= `CNT_ZERO;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				count <= i_cycles;
				o_busy <= 1'b1;
			end else if (o_busy) begin
				if (count <= `CNT_ONE) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					count <= `CNT_ZERO;
				end else begin
					count <= count - `CNT_ONE;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- adc_mux_channel_control.v ----
// Converter/multiplexer channel control: decodes I/O command pulses for the
// conversion and multiplexer device codes, holds the channel register and done flag.
// Assumes command pulses and device code come from logic on the same core clock;
// the digitized sample arrives as a word from the analog front end on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_defines.vh"

module adc_mux_channel_control (
	input wire i_core_clk,
	input wire i_rst,
	input wire [5:0] i_device_code,
	input wire i_io_command_pulse_1,
	input wire i_io_command_pulse_2,
	input wire i_io_command_pulse_3,
	input wire [`WORD_W-1:0] i_processor_working_register,
	input wire [`WORD_W-1:0] i_sample_word,
	input wire [3:0] i_word_length,
	input wire [`CHAN_W-1:0] i_chan_max,
	input wire i_int_enable,
	output reg [`CHAN_W-1:0] o_channel_address_register,
	output reg o_done_flag,
	output reg o_skip_req,
	output reg [`WORD_W-1:0] o_read_data,
	output reg o_read_valid,
	output reg o_int_req,
	output reg o_converting
);

	// Full-length conversion and channel settle, in core clock cycles
	localparam [`CNT_W-1:0] CONV_CYCLES = `CONV_CYCLES_FULL;
	localparam [`CNT_W-1:0] SETTLE_CYCLES = `SETTLE_CYCLES_ADD;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	wire sel_conv = (i_device_code == `CONV_DEV_CODE); // R13
	wire sel_mux = (i_device_code == `MUX_DEV_CODE); // R13
	wire skip_on_done_cmd = sel_conv & i_io_command_pulse_1;
	wire convert_cmd = sel_conv & i_io_command_pulse_2;
	wire read_result_cmd = sel_conv & i_io_command_pulse_3;
	wire clear_channel_cmd = sel_mux & i_io_command_pulse_1;
	wire set_channel_cmd = sel_mux & i_io_command_pulse_2;
	wire increment_channel_cmd = sel_mux & i_io_command_pulse_3;

	// ---------------------------------------------------------------
	// Channel address register
	// ---------------------------------------------------------------
	reg [`CHAN_W-1:0] next_chan;
	reg chan_changed;

	always @* begin
		next_chan = o_channel_address_register;
		if (clear_channel_cmd)
			next_chan = `CHAN_ZERO; // R9
		if (set_channel_cmd)
			next_chan = i_processor_working_register[`AC_CHAN_LSB +: `CHAN_W]; // R1 R2
		if (increment_channel_cmd) begin
			if (o_channel_address_register >= i_chan_max)
				next_chan = `CHAN_ZERO; // R4
			else
				next_chan = o_channel_address_register + `CHAN_ONE; // R3
		end
	end

	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_channel_address_register <= `CHAN_ZERO;
			chan_changed <= 1'b0;
		end else begin
			o_channel_address_register <= next_chan;
			chan_changed <= set_channel_cmd | increment_channel_cmd;
		end
	end

	// ---------------------------------------------------------------
	// Conversion timing: shorter words convert faster, channel set or increment adds settle
	// ---------------------------------------------------------------
	wire start_conv = convert_cmd | chan_changed;
	wire [`CNT_W-1:0] unused_bits = {6'h00, (`WORD_LEN_MAX - i_word_length)};
	wire [`CNT_W-1:0] len_cycles = CONV_CYCLES - (unused_bits << `BIT_STEP_SHIFT);
	wire [`CNT_W-1:0] conv_cycles = chan_changed ? (len_cycles + SETTLE_CYCLES) : len_cycles;
	wire conv_busy;
	wire conv_done;

	adc_mux_conv_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_start(start_conv),
		.i_cycles(conv_cycles),
		.o_busy(conv_busy),
		.o_done(conv_done)
	);

	// ---------------------------------------------------------------
	// Result mask: short words keep only their top bits
	// ---------------------------------------------------------------
	wire [`WORD_W-1:0] len_mask;
	genvar gb;

	generate
		for (gb = 0; gb < `WORD_W; gb = gb + 1) begin : g_mask
			assign len_mask[gb] = (gb >= unused_bits); // R12
		end
	endgenerate

	// ---------------------------------------------------------------
	// Result buffer
	// ---------------------------------------------------------------
	reg [`WORD_W-1:0] conversion_result_buffer;

	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			conversion_result_buffer <= `RES_ZERO;
		end else if (conv_done) begin
			conversion_result_buffer <= i_sample_word & len_mask; // R12
		end
	end

	// ---------------------------------------------------------------
	// Done flag: conversion end wins over a same-cycle clear
	// ---------------------------------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_done_flag <= 1'b0;
		end else if (conv_done) begin
			o_done_flag <= 1'b1; // R10
		end else if (start_conv | read_result_cmd) begin
			o_done_flag <= 1'b0; // R10 R12
		end
	end

	// ---------------------------------------------------------------
	// Conversion busy indication
	// ---------------------------------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_converting <= 1'b0;
		end else begin
			o_converting <= conv_busy | start_conv;
		end
	end

	// ---------------------------------------------------------------
	// Skip request: one cycle, only while done is set
	// ---------------------------------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_skip_req <= 1'b0;
		end else begin
			o_skip_req <= skip_on_done_cmd & o_done_flag; // R11
		end
	end

	// ---------------------------------------------------------------
	// Read port: result for one cycle, zero otherwise
	// ---------------------------------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_read_valid <= 1'b0;
			o_read_data <= `RES_ZERO;
		end else begin
			o_read_valid <= read_result_cmd;
			o_read_data <= read_result_cmd ? conversion_result_buffer : `RES_ZERO; // R12
		end
	end

	// ---------------------------------------------------------------
	// Interrupt request: level until convert, read or disable
	// ---------------------------------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int_req <= 1'b0;
		end else if (conv_done) begin
			o_int_req <= i_int_enable; // R8
		end else if (start_conv | read_result_cmd | ~i_int_enable) begin
			o_int_req <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ---- adc_mux_checker.sv ----
// Port checker for the channel control block.
// Assumes a bind onto adc_mux_channel_control.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_defines.vh"
module adc_mux_checker (
	input wire i_core_clk,
	input wire i_rst,
	input wire [5:0] i_device_code,
	input wire i_io_command_pulse_1,
	input wire i_io_command_pulse_2,
	input wire i_io_command_pulse_3,
	input wire [11:0] i_processor_working_register,
	input wire [5:0] i_chan_max,
	input wire i_int_enable,
	input wire [5:0] o_channel_address_register,
	input wire o_done_flag,
	input wire o_skip_req,
	input wire [11:0] o_read_data,
	input wire o_read_valid,
	input wire o_int_req
);
	wire mux = i_device_code == `MUX_DEV_CODE;
	wire cnv = i_device_code == `CONV_DEV_CODE;
	wire p1 = i_io_command_pulse_1;
	wire p2 = i_io_command_pulse_2;
	wire p3 = i_io_command_pulse_3;
	wire [5:0] ch = o_channel_address_register;
	wire [5:0] ac = i_processor_working_register[5:0];
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	AST_CLEAR: assert property (mux && p1 && !p2 && !p3 |=> ch == 6'h00)
		else $error("clear failed");
	AST_SET: assert property (mux && p2 && !p3 |=> ch == $past(ac))
		else $error("set failed");
	AST_INC: assert property (mux && p3 && !p1 && !p2 |=>
		ch == (($past(ch) == i_chan_max) ? 6'h00 : $past(ch) + 6'h01))
		else $error("increment failed");
	AST_OTHER: assert property (!mux |=> $stable(ch))
		else $error("channel moved");
	AST_CONV: assert property (cnv && p2 |=> !o_done_flag)
		else $error("convert kept done");
	AST_SKIP: assert property (cnv && p1 |=> o_skip_req == $past(o_done_flag))
		else $error("skip wrong");
	AST_READ: assert property (cnv && p3 |=> o_read_valid && !o_done_flag)
		else $error("read failed");
	AST_RD_IDLE: assert property (!o_read_valid |-> o_read_data == 12'h000)
		else $error("read data not idle");
	AST_INT: assert property ($rose(o_int_req) |-> $past(i_int_enable) && o_done_flag)
		else $error("interrupt wrong");
	COV_SKIP: cover property (o_skip_req);
	COV_READ: cover property (o_read_valid);
	COV_INT: cover property (o_int_req);
endmodule
bind adc_mux_channel_control adc_mux_checker u_checker (.*);
`default_nettype wire

// ---- adc_mux_host_model.sv ----
// Processor I/O bus model issuing one-cycle command pulses.
// Assumes iot is called at a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module adc_mux_host_model (
	input wire logic i_core_clk,
	output logic [5:0] o_device_code,
	output logic [2:0] o_pulse,
	output logic [11:0] o_ac
);
	initial begin
		o_device_code = 6'h00;
		o_pulse = 3'h0;
		o_ac = 12'hFFF;
	end
	// Released device code and working register lines show the inverse; pulse lines return to zero
	task automatic io_transfer_instruction(input logic [5:0] dev, input logic [2:0] p, input logic [11:0] ac);
		@(negedge i_core_clk);
		o_device_code = dev;
		o_pulse = p;
		o_ac = ac;
		@(negedge i_core_clk);
		o_pulse = 3'h0;
		o_device_code = ~dev;
		o_ac = ~ac;
	endtask
endmodule
`default_nettype wire

// ---- adc_mux_channel_control_tb.sv ----
// Self-checking bench for the channel control block.
// Assumes the host model drives commands at falling clock edges.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_defines.vh"
module adc_mux_channel_control_tb;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_int_enable = 1'b1;
	wire [5:0] dev;
	wire [5:0] ch;
	wire [2:0] p;
	wire [11:0] ac;
	wire [11:0] rd;
	wire done, skip, rv, irq, conv;
	int n_errors = 0;
	int checks = 0;
	localparam logic [5:0] MX = `MUX_DEV_CODE;
	localparam logic [5:0] CV = `CONV_DEV_CODE;
	initial forever #50 i_core_clk = ~i_core_clk;
	adc_mux_host_model u_host (.i_core_clk(i_core_clk), .o_device_code(dev), .o_pulse(p),
		.o_ac(ac));
	adc_mux_channel_control u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_device_code(dev), .i_io_command_pulse_1(p[0]), .i_io_command_pulse_2(p[1]),
		.i_io_command_pulse_3(p[2]), .i_processor_working_register(ac),
		.i_sample_word(12'hA50), .i_word_length(4'hC), .i_chan_max(6'h3F),
		.i_int_enable(i_int_enable), .o_channel_address_register(ch), .o_done_flag(done),
		.o_skip_req(skip), .o_read_data(rd), .o_read_valid(rv), .o_int_req(irq),
		.o_converting(conv));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_chan;
		u_host.io_transfer_instruction(MX, 3'h1, 12'hFFF);
		chk(ch, 6'h00);
		u_host.io_transfer_instruction(MX, 3'h2, 12'hFAA);
		chk(ch, 6'h2A);
		u_host.io_transfer_instruction(6'o55, 3'h1, 12'hFFF);
		chk(ch, 6'h2A);
		u_host.io_transfer_instruction(MX, 3'h1, 12'h000);
		u_host.io_transfer_instruction(MX, 3'h2, 12'h03E);
		u_host.io_transfer_instruction(MX, 3'h4, 12'h000);
		chk(ch, 6'h3F);
		u_host.io_transfer_instruction(MX, 3'h4, 12'h000);
		chk(ch, 6'h00);
	endtask
	task automatic poll;
		int i;
		u_host.io_transfer_instruction(CV, 3'h2, 12'h000);
		chk({done, conv}, 2'b01);
		u_host.io_transfer_instruction(CV, 3'h1, 12'h000);
		chk(skip, 1'b0);
		for (i = 0; i < 300 && skip !== 1'b1; i++)
			u_host.io_transfer_instruction(CV, 3'h1, 12'h000);
		chk({skip, done}, 2'b11);
		if (skip !== 1'b1)
			stop_test();
	endtask
	task automatic t_conv;
		poll();
		chk(irq, 1'b1);
		u_host.io_transfer_instruction(CV, 3'h4, 12'h000);
		chk({rv, rd, done, irq}, {1'b1, 12'hA50, 2'b00});
		u_host.io_transfer_instruction(MX, 3'h4, 12'h000);
		chk(ch, 6'h01);
		i_int_enable = 1'b0;
		poll();
		chk(irq, 1'b0);
	endtask
	initial begin
		repeat (12) @(negedge i_core_clk);
		i_rst = 1'b0;
		@(negedge i_core_clk);
		chk({ch, done, skip, rv, irq, rd}, 16'h0000);
		t_chan();
		t_conv();
		stop_test();
	end
endmodule
`default_nettype wire
